// ===== common/jtc_pkg.sv
// package: register map, field layout and carriers of the transport check block
package jtc_pkg;
    // printed offsets are not all multiples of four: these are indices
    localparam logic [11:0] IDX_CHECK_CONTROL   = 12'h32c;
    localparam logic [11:0] IDX_EXPECTED_LOW    = 12'h32d;
    localparam logic [11:0] IDX_EXPECTED_HIGH   = 12'h32e;
    localparam logic [11:0] IDX_CHECK_RESULT    = 12'h32f;
    localparam logic [11:0] IDX_LINK_SETUP      = 12'h333;
    localparam logic [11:0] IDX_LANE_INVERT     = 12'h334;
    localparam logic [11:0] IDX_RX_DEVICE_IDENT = 12'h400;
    localparam logic [11:0] IDX_RX_BANK_ADJUST  = 12'h401;
    localparam logic [11:0] IDX_RX_LANE0_INFO   = 12'h402;

    localparam int CTRL_ENABLE_BIT = 0;
    localparam int CTRL_CLEAR_BIT  = 1;
    localparam int CTRL_CHAN_LSB   = 2;
    localparam int CTRL_SAMPLE_LSB = 4;
    localparam logic [7:0] CTRL_WRITE_MASK = 8'h3f;

    localparam logic [1:0] CHAN_FIRST  = 2'h0;
    localparam logic [1:0] CHAN_SECOND = 2'h2;

    localparam logic [7:0] RESET_BYTE = 8'h00;

    localparam int SAMPLE_W   = 16;
    localparam int SAMPLES    = 4;
    localparam int LANES      = 8;
    localparam int LANE_W     = 32;

    // link configuration octets as carried on lane 0
    typedef struct packed {
        logic [7:0] device_ident;
        logic [3:0] adjust_step_count;
        logic [3:0] bank_ident;
        logic       adjust_direction;
        logic       phase_adjust_request;
        logic [4:0] lane0_ident;
    } jtc_link_cfg_t;

    typedef struct packed {
        logic       psel;
        logic       penable;
        logic       pwrite;
        logic [31:0] paddr;
        logic [31:0] pwdata;
    } jtc_apb_req_t;
endpackage

// ===== logic/jtc_lane_invert.sv
// per-lane polarity inversion of deserialized data
`timescale 1ns/10ps
module jtc_lane_invert #(
    parameter int LANES  = 8,
    parameter int LANE_W = 32
) (
    input  wire logic                    clk_in,
    input  wire logic                    reset_in,
    input  wire logic [LANES-1:0]        invert_mask_in,
    input  wire logic [LANES*LANE_W-1:0] lane_data_in,
    output logic      [LANES*LANE_W-1:0] lane_data_out
);
    genvar g;
    generate
        for (g = 0; g < LANES; g++) begin : g_lane
            always_ff @(posedge clk_in) begin
                if (reset_in) begin
                    lane_data_out[g*LANE_W +: LANE_W] <= '0;
                end else begin
                    lane_data_out[g*LANE_W +: LANE_W] <=
                        lane_data_in[g*LANE_W +: LANE_W] ^
                        {LANE_W{invert_mask_in[g]}};
                end
            end
        end
    endgenerate
endmodule

// ===== logic/jtc_top.sv
// transport check, lane inversion and lane 0 link info with apb registers
// Functional notes
// - sample index field picks which sample of the channel is compared
// - channel select 0 picks first channel, 2 picks second channel
// - writing clear bit as 1 clears stored check result
// - comparison runs only while check enable bit is 1
// - expected low byte supplies bits 7..0 of reference sample
// - expected high byte supplies bits 15..8 of reference sample
// - each set mask bit inverts all data bits of that logical lane
// - link fields captured from lane 0 only, read-only, reset zero
// - eight-bit received device ident stored read-only
// - four-bit bank ident stored in low nibble of bank register
// - five-bit lane ident in low bits; bit 7 reads zero
`timescale 1ns/10ps
module jtc_top #(
    parameter int LANES    = jtc_pkg::LANES,
    parameter int LANE_W   = jtc_pkg::LANE_W,
    parameter int SAMPLE_W = jtc_pkg::SAMPLE_W,
    parameter int SAMPLES  = jtc_pkg::SAMPLES
) (
    input  wire logic                          clk_in,
    input  wire logic                          reset_in,
    input  wire logic                          psel_in,
    input  wire logic                          penable_in,
    input  wire logic                          pwrite_in,
    input  wire logic [31:0]                   paddr_in,
    input  wire logic [31:0]                   pwdata_in,
    output logic      [31:0]                   prdata_out,
    output logic                               pready_out,
    output logic                               pslverr_out,
    input  wire logic [SAMPLES*SAMPLE_W-1:0]   chan_first_in,
    input  wire logic [SAMPLES*SAMPLE_W-1:0]   chan_second_in,
    input  wire logic                          sample_valid_in,
    input  wire logic                          link_cfg_valid_in,
    input  wire jtc_pkg::jtc_link_cfg_t        link_cfg_in,
    input  wire logic [2:0]                    link_cfg_lane_in,
    input  wire logic [LANES*LANE_W-1:0]       lane_data_in,
    output logic      [LANES*LANE_W-1:0]       lane_data_out,
    output logic [7:0]                         link_setup_out
);
    typedef enum logic [1:0] {
        JTC_IDLE   = 2'b01,
        JTC_ACCESS = 2'b10
    } jtc_bus_state_t;

    jtc_bus_state_t              bus_state_ff;
    jtc_pkg::jtc_apb_req_t       req;
    logic [7:0]                  control_ff;
    logic [7:0]                  expected_low_ff;
    logic [7:0]                  expected_high_ff;
    logic                        mismatch_ff;
    logic [7:0]                  link_setup_ff;
    logic [LANES-1:0]            invert_mask_ff;
    jtc_pkg::jtc_link_cfg_t      link_cfg_ff;
    logic [31:0]                 prdata_ff;
    logic                        pready_ff;
    logic                        pslverr_ff;
    logic [11:0]                 index;
    logic                        addr_ok;
    logic                        wr_take;
    logic                        rd_take;
    logic [7:0]                  rd_byte;
    logic                        rd_hit;
    logic [SAMPLES*SAMPLE_W-1:0] chan_data;
    logic [SAMPLE_W-1:0]         chosen;
    logic [SAMPLE_W-1:0]         expected;
    logic                        chan_legal;
    logic                        clear_req;

    assign req.psel    = psel_in;
    assign req.penable = penable_in;
    assign req.pwrite  = pwrite_in;
    assign req.paddr   = paddr_in;
    assign req.pwdata  = pwdata_in;

    // word-aligned byte address is four times the register index
    assign index   = req.paddr[13:2];
    assign addr_ok = (req.paddr[1:0] == 2'h0) && (req.paddr[31:14] == '0);
    // answer is registered: pready rises in the second access cycle
    assign wr_take = req.psel && req.penable && pready_ff && req.pwrite;
    assign rd_take = req.psel && req.penable && !pready_ff && !req.pwrite;

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            bus_state_ff <= JTC_IDLE;
            pready_ff    <= 1'b0;
        end else begin
            unique case (bus_state_ff)
                JTC_IDLE: begin
                    pready_ff <= 1'b0;
                    if (req.psel && req.penable) begin
                        bus_state_ff <= JTC_ACCESS;
                        pready_ff    <= 1'b1;
                    end
                end
                JTC_ACCESS: begin
                    bus_state_ff <= JTC_IDLE;
                    pready_ff    <= 1'b0;
                end
            endcase
        end
    end

    always_comb begin
        rd_byte = 8'h00;
        rd_hit  = 1'b1;
        case (index)
            jtc_pkg::IDX_CHECK_CONTROL:
                rd_byte = control_ff & jtc_pkg::CTRL_WRITE_MASK;
            jtc_pkg::IDX_EXPECTED_LOW:    rd_byte = expected_low_ff;
            jtc_pkg::IDX_EXPECTED_HIGH:   rd_byte = expected_high_ff;
            jtc_pkg::IDX_CHECK_RESULT:    rd_byte = {7'h00, mismatch_ff};
            jtc_pkg::IDX_LINK_SETUP:      rd_byte = link_setup_ff;
            jtc_pkg::IDX_LANE_INVERT:     rd_byte = 8'(invert_mask_ff);
            jtc_pkg::IDX_RX_DEVICE_IDENT:
                rd_byte = link_cfg_ff.device_ident;
            jtc_pkg::IDX_RX_BANK_ADJUST:
                rd_byte = {link_cfg_ff.adjust_step_count,
                           link_cfg_ff.bank_ident};
            jtc_pkg::IDX_RX_LANE0_INFO:
                rd_byte = {1'b0, link_cfg_ff.adjust_direction,
                           link_cfg_ff.phase_adjust_request,
                           link_cfg_ff.lane0_ident};
            default: rd_hit = 1'b0;
        endcase
    end

    // read data and error are registered on the same edge that raises pready
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            prdata_ff  <= 32'h0000_0000;
            pslverr_ff <= 1'b0;
        end else if (req.psel && req.penable && !pready_ff) begin
            prdata_ff  <= (rd_take && addr_ok && rd_hit) ?
                          {24'h00_0000, rd_byte} : 32'h0000_0000;
            pslverr_ff <= !(addr_ok && rd_hit);
        end else if (!req.psel) begin
            pslverr_ff <= 1'b0;
        end
    end

    // writable registers; unmapped or read-only targets ignore writes
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            control_ff       <= jtc_pkg::RESET_BYTE;
            expected_low_ff  <= jtc_pkg::RESET_BYTE;
            expected_high_ff <= jtc_pkg::RESET_BYTE;
            link_setup_ff    <= jtc_pkg::RESET_BYTE;
            invert_mask_ff   <= '0;
        end else if (wr_take && addr_ok) begin
            case (index)
                jtc_pkg::IDX_CHECK_CONTROL:
                    control_ff <= req.pwdata[7:0] &
                                  jtc_pkg::CTRL_WRITE_MASK;
                jtc_pkg::IDX_EXPECTED_LOW:
                    expected_low_ff <= req.pwdata[7:0];
                jtc_pkg::IDX_EXPECTED_HIGH:
                    expected_high_ff <= req.pwdata[7:0];
                jtc_pkg::IDX_LINK_SETUP:
                    link_setup_ff <= req.pwdata[7:0];
                jtc_pkg::IDX_LANE_INVERT:
                    invert_mask_ff <= req.pwdata[LANES-1:0];
                default: ;
            endcase
        end
    end

    // codes 1 and 3 name no channel, so the check is held off for them
    always_comb begin
        chan_legal = 1'b1;
        case (control_ff[jtc_pkg::CTRL_CHAN_LSB +: 2])
            jtc_pkg::CHAN_FIRST:  chan_data = chan_first_in;
            jtc_pkg::CHAN_SECOND: chan_data = chan_second_in;
            default: begin
                chan_data  = chan_first_in;
                chan_legal = 1'b0;
            end
        endcase
    end

    assign chosen = chan_data[
        control_ff[jtc_pkg::CTRL_SAMPLE_LSB +: 2] * SAMPLE_W
        +: SAMPLE_W];
    assign expected  = {expected_high_ff, expected_low_ff};
    assign clear_req = control_ff[jtc_pkg::CTRL_CLEAR_BIT];

    // the clear is a level, so a held clear keeps the flag low
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            mismatch_ff <= 1'b0;
        end else if (control_ff[jtc_pkg::CTRL_ENABLE_BIT] && chan_legal &&
                     sample_valid_in && !clear_req &&
                     (chosen != expected)) begin
            mismatch_ff <= 1'b1;
        end else if (clear_req) begin
            mismatch_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            link_cfg_ff <= '0;
        end else if (link_cfg_valid_in && link_cfg_lane_in == 3'h0) begin
            link_cfg_ff <= link_cfg_in;
        end
    end

    jtc_lane_invert #(
        .LANES  (LANES),
        .LANE_W (LANE_W)
    ) u_invert (
        .clk_in         (clk_in),
        .reset_in       (reset_in),
        .invert_mask_in (invert_mask_ff),
        .lane_data_in   (lane_data_in),
        .lane_data_out  (lane_data_out)
    );

    assign prdata_out     = prdata_ff;
    assign pready_out     = pready_ff;
    assign pslverr_out    = pslverr_ff;
    assign link_setup_out = link_setup_ff;

    property p_mismatch_sets;
        @(posedge clk_in) disable iff (reset_in)
        (control_ff[0] && chan_legal && sample_valid_in && !control_ff[1]
         && chosen != expected) |=> mismatch_ff;
    endproperty
    a_mismatch_sets: assert property (p_mismatch_sets)
        else $error("mismatch not flagged");

    property p_disabled_holds;
        @(posedge clk_in) disable iff (reset_in)
        (!control_ff[0] && !control_ff[1]) |=> $stable(mismatch_ff);
    endproperty
    a_disabled_holds: assert property (p_disabled_holds)
        else $error("flag moved while check disabled");

    property p_clear_wins;
        @(posedge clk_in) disable iff (reset_in)
        control_ff[1] |=> !mismatch_ff;
    endproperty
    a_clear_wins: assert property (p_clear_wins)
        else $error("clear did not clear flag");

    property p_sticky;
        @(posedge clk_in) disable iff (reset_in)
        (mismatch_ff && !control_ff[1]) |=> mismatch_ff;
    endproperty
    a_sticky: assert property (p_sticky)
        else $error("flag dropped without clear");

    property p_match_no_set;
        @(posedge clk_in) disable iff (reset_in)
        (!mismatch_ff && chosen == expected) |=> !mismatch_ff;
    endproperty
    a_match_no_set: assert property (p_match_no_set)
        else $error("flag set on matching sample");

    property p_lane0_only;
        @(posedge clk_in) disable iff (reset_in)
        (link_cfg_valid_in && link_cfg_lane_in != 3'h0) |=>
            $stable(link_cfg_ff);
    endproperty
    a_lane0_only: assert property (p_lane0_only)
        else $error("link info taken from other lane");

    property p_lane0_capture;
        @(posedge clk_in) disable iff (reset_in)
        (link_cfg_valid_in && link_cfg_lane_in == 3'h0) |=>
            link_cfg_ff == $past(link_cfg_in);
    endproperty
    a_lane0_capture: assert property (p_lane0_capture)
        else $error("lane 0 link info not captured");

    property p_invert;
        @(posedge clk_in) disable iff (reset_in)
        ##1 lane_data_out[LANE_W-1:0] == ($past(lane_data_in[LANE_W-1:0])
            ^ {LANE_W{$past(invert_mask_ff[0])}});
    endproperty
    a_invert: assert property (p_invert)
        else $error("lane 0 inversion wrong");

    property p_reserved_ctrl;
        @(posedge clk_in) disable iff (reset_in)
        control_ff[7:6] == 2'h0;
    endproperty
    a_reserved_ctrl: assert property (p_reserved_ctrl)
        else $error("reserved control bits set");

    property p_illegal_chan_idle;
        @(posedge clk_in) disable iff (reset_in)
        (!chan_legal && !mismatch_ff) |=> !mismatch_ff;
    endproperty
    a_illegal_chan_idle: assert property (p_illegal_chan_idle)
        else $error("flag set for unnamed channel code");

    property p_pready_pulse;
        @(posedge clk_in) disable iff (reset_in)
        pready_ff |=> !pready_ff;
    endproperty
    a_pready_pulse: assert property (p_pready_pulse)
        else $error("pready held past one cycle");
endmodule

// ===== tb/jtc_tx_model.sv
// behavioural link transmitter: samples, config octets and lane data
`timescale 1ns/10ps
module jtc_tx_model (
    input  wire logic             clk_in,
    output logic [63:0]           chan_first_out,
    output logic [63:0]           chan_second_out,
    output logic                  sample_valid_out,
    output logic                  link_cfg_valid_out,
    output jtc_pkg::jtc_link_cfg_t link_cfg_out,
    output logic [2:0]            link_cfg_lane_out,
    output logic [255:0]          lane_data_out
);
    initial begin
        chan_first_out     = '0;
        chan_second_out    = '0;
        sample_valid_out   = 1'b0;
        link_cfg_valid_out = 1'b0;
        link_cfg_out       = '0;
        link_cfg_lane_out  = 3'h0;
        lane_data_out      = '0;
    end
    // one valid beat; afterwards the lines show the inverse, never stale data
    task automatic send_samples(input logic [63:0] a, input logic [63:0] b);
        @(posedge clk_in);
        chan_first_out   <= a;
        chan_second_out  <= b;
        sample_valid_out <= 1'b1;
        @(posedge clk_in);
        chan_first_out   <= ~a;
        chan_second_out  <= ~b;
        sample_valid_out <= 1'b0;
    endtask
    // adjust fields go out as zero on the valid beat, whatever a scenario hands in
    task automatic send_cfg(input jtc_pkg::jtc_link_cfg_t c,
                            input logic [2:0] lane);
        jtc_pkg::jtc_link_cfg_t s;
        s = c;
        s.adjust_step_count    = 4'h0;
        s.adjust_direction     = 1'b0;
        s.phase_adjust_request = 1'b0;
        @(posedge clk_in);
        link_cfg_out       <= s;
        link_cfg_lane_out  <= lane;
        link_cfg_valid_out <= 1'b1;
        @(posedge clk_in);
        link_cfg_out       <= ~s;
        link_cfg_valid_out <= 1'b0;
    endtask
    task automatic set_lanes(input logic [255:0] d);
        @(posedge clk_in);
        lane_data_out <= d;
    endtask
endmodule

// ===== tb/tb_jtc_top.sv
// self-checking bench for the transport check and link info block
`timescale 1ns/10ps
module tb_jtc_top;
    logic                   clk;
    logic                   rst;
    logic                   psel;
    logic                   penable;
    logic                   pwrite;
    logic [31:0]            paddr;
    logic [31:0]            pwdata;
    logic [31:0]            prdata;
    logic                   pready;
    logic                   pslverr;
    logic [63:0]            chan_a;
    logic [63:0]            chan_b;
    logic                   smp_vld;
    logic                   cfg_vld;
    jtc_pkg::jtc_link_cfg_t cfg;
    logic [2:0]             cfg_lane;
    logic [255:0]           lane_in;
    logic [255:0]           lane_out;
    logic [7:0]             setup;
    logic [31:0]            rd;
    logic                   err;
    int                     errors;
    int                     checks_done;
    int                     cycles;

    jtc_top u_dut (
        .clk_in(clk), .reset_in(rst), .psel_in(psel), .penable_in(penable),
        .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
        .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
        .chan_first_in(chan_a), .chan_second_in(chan_b),
        .sample_valid_in(smp_vld), .link_cfg_valid_in(cfg_vld),
        .link_cfg_in(cfg), .link_cfg_lane_in(cfg_lane),
        .lane_data_in(lane_in), .lane_data_out(lane_out),
        .link_setup_out(setup)
    );
    jtc_tx_model u_tx (
        .clk_in(clk), .chan_first_out(chan_a), .chan_second_out(chan_b),
        .sample_valid_out(smp_vld), .link_cfg_valid_out(cfg_vld),
        .link_cfg_out(cfg), .link_cfg_lane_out(cfg_lane),
        .lane_data_out(lane_in)
    );

    always #20 clk = ~clk;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // waits for pready however long it takes; the watchdog ends a hang
    task automatic apb(input logic w, input logic [11:0] idx,
                       input logic [7:0] d);
        @(posedge clk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= {18'h0, idx, 2'b00};
        pwdata  <= {24'h0, d};
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] idx, input logic [7:0] d);
        apb(1'b1, idx, d);
    endtask
    task automatic rchk(input logic [11:0] idx, input logic [7:0] exp);
        apb(1'b0, idx, 8'h00);
        chk(rd, {24'h0, exp});
    endtask
    task automatic close_out();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic t_reset_values();
        for (int i = 0; i < 9; i++) begin
            rchk(12'h32c + 12'(i), 8'h00);
        end
        rchk(jtc_pkg::IDX_RX_DEVICE_IDENT, 8'h00);
        rchk(jtc_pkg::IDX_RX_BANK_ADJUST, 8'h00);
        rchk(jtc_pkg::IDX_RX_LANE0_INFO, 8'h00);
        apb(1'b0, 12'h3ff, 8'h00);
        chk({31'h0, err}, 32'h1);
        $display("reset values done");
    endtask
    task automatic t_regs();
        wr(jtc_pkg::IDX_CHECK_CONTROL, 8'hfe);
        rchk(jtc_pkg::IDX_CHECK_CONTROL, 8'h3e);
        wr(jtc_pkg::IDX_CHECK_CONTROL, 8'h00);
        wr(jtc_pkg::IDX_CHECK_RESULT, 8'hff);
        rchk(jtc_pkg::IDX_CHECK_RESULT, 8'h00);
        wr(jtc_pkg::IDX_LINK_SETUP, 8'h01);
        rchk(jtc_pkg::IDX_LINK_SETUP, 8'h01);
        chk({24'h0, setup}, 32'h1);
        $display("register access done");
    endtask
    task automatic t_check();
        logic [15:0] e;
        logic [15:0] f;
        logic [63:0] a;
        logic [63:0] b;
        logic [1:0]  c;
        for (int ch = 0; ch < 2; ch++) begin
            for (int s = 0; s < 4; s++) begin
                c = ch ? jtc_pkg::CHAN_SECOND : jtc_pkg::CHAN_FIRST;
                e = 16'hc350 + 16'(ch * 4 + s);
                // one bit flipped per pass, in the low byte for even and the high byte for odd samples, so both reference bytes count
                f = s[0] ? 16'h8000 : 16'h0001;
                for (int k = 0; k < 4; k++) begin
                    a[16*k+:16] = (ch == 0 && k == s) ? e : ~e;
                    b[16*k+:16] = (ch == 1 && k == s) ? e : ~e;
                end
                wr(jtc_pkg::IDX_EXPECTED_LOW, e[7:0]);
                wr(jtc_pkg::IDX_EXPECTED_HIGH, e[15:8]);
                wr(jtc_pkg::IDX_CHECK_CONTROL, {2'h0, s[1:0], c, 2'h1});
                u_tx.send_samples(a, b);
                rchk(jtc_pkg::IDX_CHECK_RESULT, 8'h00);
                u_tx.send_samples(ch ? a : a ^ (64'(f) << 16 * s),
                                  ch ? b ^ (64'(f) << 16 * s) : b);
                rchk(jtc_pkg::IDX_CHECK_RESULT, 8'h01);
                u_tx.send_samples(a, b);
                rchk(jtc_pkg::IDX_CHECK_RESULT, 8'h01);
                wr(jtc_pkg::IDX_CHECK_CONTROL, {2'h0, s[1:0], c, 2'h3});
                rchk(jtc_pkg::IDX_CHECK_RESULT, 8'h00);
                wr(jtc_pkg::IDX_CHECK_CONTROL, 8'h00);
            end
        end
        // channel code 1 names no converter: a mismatch must not be flagged
        wr(jtc_pkg::IDX_CHECK_CONTROL, 8'h05);
        u_tx.send_samples(64'h0, 64'h0);
        rchk(jtc_pkg::IDX_CHECK_RESULT, 8'h00);
        wr(jtc_pkg::IDX_CHECK_CONTROL, 8'h00);
        u_tx.send_samples(64'h0, 64'h0);
        rchk(jtc_pkg::IDX_CHECK_RESULT, 8'h00);
        $display("transport check done");
    endtask
    task automatic t_lanes();
        logic [255:0] d;
        logic [7:0]   m;
        m = 8'ha5;
        for (int k = 0; k < 8; k++) begin
            d[32*k+:32] = 32'h5a0000f0 ^ (32'h01010101 * k);
        end
        wr(jtc_pkg::IDX_LANE_INVERT, m);
        rchk(jtc_pkg::IDX_LANE_INVERT, m);
        u_tx.set_lanes(d);
        repeat (2) @(posedge clk);
        for (int k = 0; k < 8; k++) begin
            chk(lane_out[32*k+:32], d[32*k+:32] ^ {32{m[k]}});
        end
        $display("lane inversion done");
    endtask
    task automatic t_link();
        jtc_pkg::jtc_link_cfg_t c;
        c = '{8'h9c, 4'h0, 4'h7, 1'b0, 1'b0, 5'h15};
        u_tx.send_cfg(c, 3'h3);
        rchk(jtc_pkg::IDX_RX_DEVICE_IDENT, 8'h00);
        u_tx.send_cfg(c, 3'h0);
        rchk(jtc_pkg::IDX_RX_DEVICE_IDENT, 8'h9c);
        rchk(jtc_pkg::IDX_RX_BANK_ADJUST, 8'h07);
        rchk(jtc_pkg::IDX_RX_LANE0_INFO, 8'h15);
        c = '{8'h63, 4'h3, 4'h8, 1'b1, 1'b1, 5'h0a};
        u_tx.send_cfg(c, 3'h0);
        rchk(jtc_pkg::IDX_RX_DEVICE_IDENT, 8'h63);
        rchk(jtc_pkg::IDX_RX_BANK_ADJUST, 8'h08);
        rchk(jtc_pkg::IDX_RX_LANE0_INFO, 8'h0a);
        wr(jtc_pkg::IDX_RX_LANE0_INFO, 8'hff);
        rchk(jtc_pkg::IDX_RX_LANE0_INFO, 8'h0a);
        $display("link info done");
    endtask

    initial begin
        clk = 1'b0;
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        errors = 0;
        checks_done = 0;
        cycles = 0;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        t_reset_values();
        t_regs();
        t_check();
        t_lanes();
        t_link();
        close_out();
    end
    // whole run takes well under a thousand cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errors++;
            close_out();
        end
    end
endmodule
